/* shared/tag_pkg.sv */
// Shared constants and types for the timed-access write guard and its core-side end.
`default_nettype none
package tag_pkg;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Key register and key sequence
    // ----------------------------------------------------------------
    localparam logic [7:0] TAG_KEY_ADDR = 8'hC7;
    localparam logic [7:0] TAG_KEY_FIRST = 8'hAA;
    localparam logic [7:0] TAG_KEY_SECOND = 8'h55;

    // ----------------------------------------------------------------
    // Timing in machine cycles
    // ----------------------------------------------------------------
    localparam logic [2:0] TAG_KEY_GAP_MC = 3'h3;
    localparam logic [2:0] TAG_WINDOW_MC = 3'h3;
    localparam int TAG_CLKS_PER_MC = 4;
    localparam logic [2:0] TAG_CNT_RESET = 3'h0;

    // ----------------------------------------------------------------
    // Guarded registers: addresses, guarded-bit masks and reset values
    // ----------------------------------------------------------------
    localparam int TAG_NREG = 5;
    localparam int TAG_IDX_WDOG = 0;
    localparam int TAG_IDX_EXT = 1;
    localparam int TAG_IDX_TRIM = 2;
    localparam int TAG_IDX_ROM = 3;
    localparam int TAG_IDX_RTC = 4;
    localparam logic [TAG_NREG-1:0][7:0] TAG_REG_ADDR = {8'hF9, 8'hC2, 8'h96, 8'h91, 8'hD8};
    localparam logic [TAG_NREG-1:0][7:0] TAG_REG_GUARD = {8'h05, 8'h07, 8'hFF, 8'h01, 8'h4B};
    localparam logic [TAG_NREG-1:0][7:0] TAG_REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h02};

    // ----------------------------------------------------------------
    // Bit positions inside the watchdog and clock control registers
    // ----------------------------------------------------------------
    localparam int TAG_WDOG_RESTART_BIT = 0;
    localparam int TAG_WDOG_RESET_EN_BIT = 1;
    localparam int TAG_WDOG_IRQ_BIT = 3;
    localparam int TAG_WDOG_POR_BIT = 6;
    localparam int TAG_RTC_ENABLE_BIT = 0;
    localparam int TAG_RTC_WRITE_EN_BIT = 2;

    // ----------------------------------------------------------------
    // Key sequence states and core instruction states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TAG_IDLE = 3'b001,
        TAG_ARMED = 3'b010,
        TAG_OPEN = 3'b100
    } tag_state_type;

    typedef enum logic [1:0] {
        TAG_CORE_IDLE = 2'b01,
        TAG_CORE_BUSY = 2'b10
    } tag_core_state_type;
endpackage
`default_nettype wire

/* shared/tag_bus_if.sv */
// Special-function-register write path between the core and the write guard.
`default_nettype none
interface tag_bus_if;
    timeunit 1ns;
    timeprecision 1ns;
    logic mc_tick;
    logic wr;
    logic [7:0] addr;
    logic [7:0] mask;
    logic [7:0] data;

    modport core (
        output mc_tick,
        output wr,
        output addr,
        output mask,
        output data
    );

    modport guard (
        input mc_tick,
        input wr,
        input addr,
        input mask,
        input data
    );
endinterface
`default_nettype wire

/* src/tag_core.sv */
// Core-side end: machine-cycle timing and the register write path.
`default_nettype none
module tag_core
    import tag_pkg::*;
#(
    parameter int CLKS_PER_MC = TAG_CLKS_PER_MC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    tag_bus_if.core bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_mask,
    input wire logic [7:0] cmd_data,
    input wire logic [2:0] cmd_cycles
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Machine-cycle divider
    // ----------------------------------------------------------------
    localparam int PW = (CLKS_PER_MC > 1) ? $clog2(CLKS_PER_MC) : 1;
    localparam logic [PW-1:0] PHASE_LAST = PW'(CLKS_PER_MC - 1);

    logic [PW-1:0] phase;
    tag_core_state_type state;
    logic [2:0] remain;
    logic is_write;
    logic [7:0] addr_q;
    logic [7:0] mask_q;
    logic [7:0] data_q;
    wire logic tick = (phase == PHASE_LAST);
    wire logic take = cmd_valid && cmd_ready;
    wire logic last_mc = (state == TAG_CORE_BUSY) && tick && (remain == 3'h1);

    // The divider runs free so the guard sees machine cycles even while idle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= '0;
        end else if (ce) begin
            phase <= tick ? '0 : phase + PW'(1);
        end
    end

    // ----------------------------------------------------------------
    // Instruction execution
    // ----------------------------------------------------------------
    // Each command lasts cmd_cycles machine cycles, one when cmd_cycles is zero; its write lands on the last one.
    // Software keeps the key pair consecutive and precedes guarded writes with it. [R01] [R09]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TAG_CORE_IDLE;
            remain <= 3'h0;
            is_write <= 1'b0;
            addr_q <= 8'h00;
            mask_q <= 8'h00;
            data_q <= 8'h00;
        end else if (ce) begin
            if (take) begin
                state <= TAG_CORE_BUSY;
                remain <= (cmd_cycles == 3'h0) ? 3'h1 : cmd_cycles;
                is_write <= cmd_write;
                addr_q <= cmd_addr;
                mask_q <= cmd_mask;
                data_q <= cmd_data;
            end else if (last_mc) begin
                state <= TAG_CORE_IDLE;
            end else if ((state == TAG_CORE_BUSY) && tick) begin
                remain <= remain - 3'h1;
            end
        end
    end

    // Write strobe and tick are handshake signals; the payload comes from flops.
    assign cmd_ready = (state == TAG_CORE_IDLE);
    assign bus.mc_tick = tick && ce;
    assign bus.wr = last_mc && is_write && ce;
    assign bus.addr = addr_q;
    assign bus.mask = mask_q;
    assign bus.data = data_q;
endmodule
`default_nettype wire

/* src/tag_guard.sv */
// Timed-access write guard: key sequence, write window and the guarded register bits.
`default_nettype none
// Overview of operation
// R01: Key values written in order open access.
// R02: Second key within three machine cycles.
// R03: Window stays open three machine cycles.
// R04: Open window lets any guarded bit change.
// R05: Closed window blocks guarded bits, keeps value.
// R06: Broken sequence discards progress, restart needed.
// R07: Guarded write must finish within three cycles.
// R08: Watchdog reset enable is guarded against clears.
// R09: Software always runs the key procedure first.
// R10: Watchdog, power, trim, clock, size bits guarded.
// R11: Wrong second key returns guard to idle.
module tag_guard
    import tag_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    tag_bus_if.guard bus,
    output logic [7:0] watchdog_control,
    output logic [7:0] ext_control,
    output logic [7:0] trim_control,
    output logic [7:0] rom_size,
    output logic [7:0] clock_control,
    output logic watchdog_reset_enable,
    output logic watchdog_restart,
    output logic watchdog_irq_flag,
    output logic power_on_flag,
    output logic clock_enable,
    output logic clock_write_enable,
    output logic window_open,
    output logic key_pending,
    output logic write_blocked,
    output logic [7:0] blocked_count
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Key sequence decoding
    // ----------------------------------------------------------------
    tag_state_type state;
    tag_state_type next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;

    // Machine cycles elapsed since the last key write, this cycle's tick included.
    // A key or guarded write always lands on the last tick of its instruction,
    // so counting the coincident tick makes an instruction of n machine cycles
    // count as n. Three bits are enough because both the key gap and the
    // window end as soon as the count passes three.
    wire logic key_wr = bus.wr && (bus.addr == TAG_KEY_ADDR);
    wire logic is_first = (bus.data == TAG_KEY_FIRST);
    wire logic is_second = (bus.data == TAG_KEY_SECOND);
    wire logic [2:0] elapsed = cnt + {2'b00, bus.mc_tick};
    wire logic key_late = (elapsed > TAG_KEY_GAP_MC);
    wire logic window_late = (elapsed > TAG_WINDOW_MC);

    // A guarded write is honoured only if it completes inside the window. [R07]
    // Several guarded writes may land in one window; each is judged on its own
    // completion tick, so a slow second write is refused even though the first
    // one succeeded.
    wire logic window_ok = (state == TAG_OPEN) && !window_late;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // The first key restarts the sequence from any state, so a stray write
    // never leaves half-finished progress behind.
    // Any other key write except a timely second key while armed, or a count that runs past three, drops back to
    // idle; software then has to start again with the first key.
    always_comb begin
        next_state = state;
        next_cnt = elapsed;
        case (state)
            TAG_IDLE: begin
                next_cnt = TAG_CNT_RESET;
                if (key_wr && is_first) begin
                    next_state = TAG_ARMED; // [R01]
                end
            end
            TAG_ARMED: begin
                if (key_wr && is_second && !key_late) begin
                    next_state = TAG_OPEN; // [R01] [R03]
                    next_cnt = TAG_CNT_RESET;
                end else if (key_wr && is_first) begin
                    next_state = TAG_ARMED; // [R06]
                    next_cnt = TAG_CNT_RESET;
                end else if (key_wr) begin
                    next_state = TAG_IDLE; // [R11] [R02]
                    next_cnt = TAG_CNT_RESET;
                end else if (key_late) begin
                    next_state = TAG_IDLE; // [R02] [R06]
                    next_cnt = TAG_CNT_RESET;
                end
            end
            TAG_OPEN: begin
                if (key_wr && is_first) begin
                    next_state = TAG_ARMED; // [R06]
                    next_cnt = TAG_CNT_RESET;
                end else if (key_wr || window_late) begin
                    next_state = TAG_IDLE; // [R03]
                    next_cnt = TAG_CNT_RESET;
                end
            end
            default: begin
                next_state = TAG_IDLE;
                next_cnt = TAG_CNT_RESET;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Sequence state
    // ----------------------------------------------------------------
    // Clock enable low freezes the sequence together with the registers.
    // The machine-cycle tick is gated by the same enable, so a frozen spell
    // neither ages an armed sequence nor shortens an open window.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TAG_IDLE;
            cnt <= TAG_CNT_RESET;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Guarded registers
    // ----------------------------------------------------------------
    // Register contents and refusal flags are nets because each entry of the
    // loop below drives its own slice of them.
    wire logic [TAG_NREG-1:0][7:0] regs;
    wire logic [TAG_NREG-1:0] blocked_hit;

    genvar i;
    generate
        for (i = 0; i < TAG_NREG; i++) begin : g_reg
            logic [7:0] reg_q;
            wire logic hit = bus.wr && (bus.addr == TAG_REG_ADDR[i]);
            wire logic guard_hit = ((bus.mask & TAG_REG_GUARD[i]) != 8'h00);
            // Outside the window the guarded bits drop out of the write mask,
            // so a bit-clear by runaway code leaves them untouched. [R05] [R08]
            wire logic [7:0] eff_mask = window_ok ? bus.mask
                                                  : (bus.mask & ~TAG_REG_GUARD[i]); // [R04]
            wire logic [7:0] next_reg = (reg_q & ~eff_mask) | (bus.data & eff_mask);
            assign blocked_hit[i] = hit && !window_ok && guard_hit;
            assign regs[i] = reg_q;

            // Unguarded bits of the same register stay freely writable. [R10]
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    reg_q <= TAG_REG_RESET[i];
                end else if (ce && hit) begin
                    reg_q <= next_reg;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Blocked-write status
    // ----------------------------------------------------------------
    // A refused attempt pulses for one cycle and bumps a saturating counter,
    // which lets software or a monitor notice runaway code.
    // The counter saturates so that a long run of refusals never reads as few.
    wire logic any_blocked = |blocked_hit;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_blocked <= 1'b0;
            blocked_count <= 8'h00;
        end else if (ce) begin
            write_blocked <= any_blocked; // [R05]
            if (any_blocked && (blocked_count != 8'hFF)) begin
                blocked_count <= blocked_count + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Register contents and named guarded bits for the owning units.
    // The owning units see plain levels and need no knowledge of the key
    // sequence, which keeps the guard the only place that enforces it.
    assign watchdog_control = regs[TAG_IDX_WDOG];
    assign ext_control = regs[TAG_IDX_EXT];
    assign trim_control = regs[TAG_IDX_TRIM];
    assign rom_size = regs[TAG_IDX_ROM];
    assign clock_control = regs[TAG_IDX_RTC];
    assign watchdog_reset_enable = regs[TAG_IDX_WDOG][TAG_WDOG_RESET_EN_BIT]; // [R08]
    assign watchdog_restart = regs[TAG_IDX_WDOG][TAG_WDOG_RESTART_BIT];
    assign watchdog_irq_flag = regs[TAG_IDX_WDOG][TAG_WDOG_IRQ_BIT];
    assign power_on_flag = regs[TAG_IDX_WDOG][TAG_WDOG_POR_BIT];
    assign clock_enable = regs[TAG_IDX_RTC][TAG_RTC_ENABLE_BIT];
    assign clock_write_enable = regs[TAG_IDX_RTC][TAG_RTC_WRITE_EN_BIT];

    // Status straight from the state flops.
    // The codes are one-hot, so each flag is a single flop and carries no
    // glitch from the next-state logic.
    assign window_open = (state == TAG_OPEN);
    assign key_pending = (state == TAG_ARMED);
endmodule
`default_nettype wire

/* tb/tag_guard_assertions.sv */
// Checker for the key sequence and the write window on the register path.
`default_nettype none
module tag_guard_assertions
    import tag_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mc_tick,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] mask,
    input wire logic [7:0] data,
    input wire logic window_open,
    input wire logic key_pending,
    input wire logic write_blocked,
    input wire logic [7:0] trim_control,
    input wire logic watchdog_reset_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] tk;
    logic kw;
    logic tw;
    logic [3:0] seen;
    // Ticks since the last key write, the coincident tick included in seen.
    assign kw = wr && addr == TAG_KEY_ADDR;
    assign tw = wr && addr == TAG_REG_ADDR[TAG_IDX_TRIM];
    assign seen = {1'b0, tk} + {3'h0, mc_tick};
    // The count saturates so a long idle spell never wraps back into range.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tk <= 3'h0;
        end else if (kw) begin
            tk <= 3'h0;
        end else if (mc_tick && tk != 3'h7) begin
            tk <= tk + 3'h1;
        end
    end
    sequence s_first_key;
        kw && data == TAG_KEY_FIRST;
    endsequence
    sequence s_second_key;
        key_pending && kw && data == TAG_KEY_SECOND;
    endsequence
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_key_arms: assert property (s_first_key |=> key_pending)
        else $error("first key did not arm the guard");
    a_gap_opens: assert property (s_second_key ##0 seen <= 4'h3 |=> window_open)
        else $error("timely second key did not open the window");
    a_gap_late: assert property (s_second_key ##0 seen > 4'h3 |=> !window_open)
        else $error("late second key opened the window");
    a_wrong_key: assert property (key_pending && kw && data != TAG_KEY_SECOND
        && data != TAG_KEY_FIRST |=> !key_pending && !window_open)
        else $error("wrong second key left the guard busy");
    a_window_holds: assert property (window_open && !kw && seen < 4'h4 |=> window_open)
        else $error("window closed early");
    a_window_ends: assert property (window_open && mc_tick && tk == 3'h3 && !kw
        |=> !window_open)
        else $error("window stayed open too long");
    a_open_write: assert property (window_open && tw && seen <= 4'h3 |=>
        trim_control == (($past(data) & $past(mask)) | ($past(trim_control) & ~$past(mask))))
        else $error("write inside the window was lost");
    a_late_write: assert property (window_open && tw && seen > 4'h3 |=>
        $stable(trim_control))
        else $error("write after the window took effect");
    a_closed_keeps: assert property (!window_open && tw && mask != 8'h00 |=>
        $stable(trim_control) ##[0:1] write_blocked)
        else $error("closed window let a guarded write through");
    a_wdog_kept: assert property (!window_open && wr && mask[1] &&
        addr == TAG_REG_ADDR[TAG_IDX_WDOG] |=> $stable(watchdog_reset_enable))
        else $error("watchdog reset enable changed without a window");
endmodule
`default_nettype wire

/* tb/timed_access_write_guard_tb.sv */
// Self-checking bench: core and guard joined, driven by instruction commands.
`default_nettype none
module timed_access_write_guard_tb
    import tag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [7:0] cmd_mask = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic [2:0] cmd_cycles = 3'h1;
    wire logic [TAG_NREG-1:0][7:0] regs;
    logic [7:0] exp_regs [TAG_NREG];
    logic window_open, key_pending, write_blocked, wdog_en;
    logic wd_restart, wd_irq, por_flag, clk_en, clk_we;
    wire logic [7:0] named_bits = {2'b00, wd_restart, wdog_en, wd_irq, por_flag, clk_en, clk_we};
    logic [7:0] blocked_count;
    int failures = 0;
    int num_checks = 0;
    tag_bus_if bus ();
    always #50 clk = ~clk;
    tag_core i_tag_core (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_mask(cmd_mask), .cmd_data(cmd_data), .cmd_cycles(cmd_cycles));
    tag_guard i_tag_guard (.clk(clk), .rst(rst), .ce(ce), .bus(bus),
        .watchdog_control(regs[TAG_IDX_WDOG]), .ext_control(regs[TAG_IDX_EXT]),
        .trim_control(regs[TAG_IDX_TRIM]), .rom_size(regs[TAG_IDX_ROM]),
        .clock_control(regs[TAG_IDX_RTC]), .watchdog_reset_enable(wdog_en),
        .watchdog_restart(wd_restart), .watchdog_irq_flag(wd_irq), .power_on_flag(por_flag),
        .clock_enable(clk_en), .clock_write_enable(clk_we), .window_open(window_open),
        .key_pending(key_pending),
        .write_blocked(write_blocked), .blocked_count(blocked_count));
    tag_guard_assertions i_tag_guard_assertions (.clk(clk), .rst(rst), .mc_tick(bus.mc_tick),
        .wr(bus.wr), .addr(bus.addr), .mask(bus.mask), .data(bus.data),
        .window_open(window_open), .key_pending(key_pending), .write_blocked(write_blocked),
        .trim_control(regs[TAG_IDX_TRIM]), .watchdog_reset_enable(wdog_en));
    // ----------------------------------------------------------------
    // Command tasks and comparisons
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bounded wait, so a core that never returns to idle cannot hang the run.
    task automatic wait_ready();
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 64) begin
            @(negedge clk);
            k++;
        end
        check("cmd_ready", 8'h01, {7'h00, cmd_ready});
    endtask
    // One instruction; returns once its write has landed and the core is idle.
    task automatic run(input logic w, input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] d, input logic [2:0] n);
        wait_ready();
        cmd_write = w;
        cmd_addr = a;
        cmd_mask = m;
        cmd_data = d;
        cmd_cycles = n;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        @(negedge clk);
        wait_ready();
    endtask
    task automatic key(input logic [7:0] d);
        run(1'b1, TAG_KEY_ADDR, 8'hFF, d, 3'h3);
    endtask
    task automatic open_window();
        key(TAG_KEY_FIRST);
        key(TAG_KEY_SECOND);
    endtask
    task automatic trim(input logic [7:0] d, input logic [2:0] n);
        run(1'b1, TAG_REG_ADDR[TAG_IDX_TRIM], 8'hFF, d, n);
    endtask
    task automatic check_regs();
        for (int i = 0; i < TAG_NREG; i++) begin
            check("register", exp_regs[i], regs[i]);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand clock cycles.
    initial begin
        #(3000 * 100);
        failures++;
        $display("[ERR] run time expected done seen timeout");
        print_verdict();
    end
    // Main sequence; a refused write leaves the expected register untouched.
    initial begin
        for (int i = 0; i < TAG_NREG; i++) exp_regs[i] = TAG_REG_RESET[i];
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check_regs();
        for (int i = 0; i < TAG_NREG; i++) begin
            open_window();
            run(1'b1, TAG_REG_ADDR[i], TAG_REG_GUARD[i], 8'hFF, 3'h3);
            exp_regs[i] = exp_regs[i] | TAG_REG_GUARD[i];
        end
        check_regs();
        check("named bits", 8'h3F, named_bits);
        run(1'b1, TAG_REG_ADDR[TAG_IDX_WDOG], 8'h02, 8'h00, 3'h2);
        check("blocked_count", 8'h01, blocked_count);
        key(TAG_KEY_FIRST);
        run(1'b0, 8'h00, 8'h00, 8'h00, 3'h1);
        key(TAG_KEY_SECOND);
        trim(8'h5A, 3'h2);
        open_window();
        run(1'b0, 8'h00, 8'h00, 8'h00, 3'h1);
        trim(8'h3C, 3'h3);
        key(TAG_KEY_FIRST);
        key(8'h33);
        key(TAG_KEY_SECOND);
        trim(8'h66, 3'h2);
        key(TAG_KEY_SECOND);
        key(TAG_KEY_FIRST);
        trim(8'h99, 3'h2);
        check("blocked_count", 8'h05, blocked_count);
        check_regs();
        open_window();
        run(1'b0, 8'h00, 8'h00, 8'h00, 3'h1);
        trim(8'hA5, 3'h2);
        exp_regs[TAG_IDX_TRIM] = 8'hA5;
        // A frozen spell inside an open window must not age the window.
        open_window();
        ce = 1'b0;
        repeat (20) @(negedge clk);
        ce = 1'b1;
        trim(8'hC3, 3'h2);
        exp_regs[TAG_IDX_TRIM] = 8'hC3;
        open_window();
        run(1'b1, TAG_REG_ADDR[TAG_IDX_RTC], 8'h01, 8'h00, 3'h2);
        run(1'b1, TAG_REG_ADDR[TAG_IDX_RTC], 8'h04, 8'h00, 3'h2);
        exp_regs[TAG_IDX_RTC] = exp_regs[TAG_IDX_RTC] & 8'hFE;
        check_regs();
        check("named bits", 8'h3D, named_bits);
        check("blocked_count", 8'h06, blocked_count);
        print_verdict();
    end
endmodule
`default_nettype wire
